/* hdl/drc_pkg.sv */
// What this block does
// - Low-power waits for current sample/block end
// - Low-power state masks all core interrupts
// - Bit0 low-power request, upper bits reserved
// - Five-bit frame strobe selector, reset base rate
// - Codes 0-4 pick generator one rates
// - Codes 5-7 pick generator two rates
// - Codes 8-11 pick serial input rates
// - Codes 12-15 pick serial output rates
// - Code 16 picks S/PDIF receiver rate
// - Launch bit rising edge starts program counter
// - Launch bit falling edge does nothing
// - Program counter starts at start address
package drc_pkg;
  // ==========================================================
  // Register map (word addresses on the control port)
  localparam logic [15:0] DRC_ADDR_LOW_POWER = 16'hf400;
  localparam logic [15:0] DRC_ADDR_STROBE_SRC = 16'hf401;
  localparam logic [15:0] DRC_ADDR_LAUNCH = 16'hf402;
  // ==========================================================
  // Reset values
  localparam logic [15:0] DRC_RST_LOW_POWER = 16'h0000;
  localparam logic [4:0] DRC_RST_STROBE_SRC = 5'h02;
  localparam logic [15:0] DRC_RST_LAUNCH = 16'h0000;
  localparam logic [15:0] DRC_RST_START_ADDR = 16'h0000;
  // ==========================================================
  // Field layout
  localparam int DRC_SEL_W = 5;
  localparam int DRC_NUM_SRC = 17;
  localparam logic [4:0] DRC_SEL_GEN1 = 5'h00;
  localparam logic [4:0] DRC_SEL_GEN2 = 5'h05;
  localparam logic [4:0] DRC_SEL_SIN = 5'h08;
  localparam logic [4:0] DRC_SEL_SOUT = 5'h0c;
  localparam logic [4:0] DRC_SEL_SPDIF = 5'h10;
  // ==========================================================
  // Grouped frame strobe sources, all one-cycle pulses
  typedef struct packed {
    logic spdif;       // Receiver recovered rate
    logic [3:0] sout;  // Serial output ports 3..0
    logic [3:0] sin;   // Serial input ports 3..0
    logic [2:0] gen2;  // /6, /3, x2/3
    logic [4:0] gen1;  // x4, x2, x1, /2, /4 (msb..lsb)
  } drc_strobes_t;
  // Host control port write/read request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } drc_req_t;
  // Run state of the sequencer
  typedef enum logic [1:0] {DRC_IDLE, DRC_RUN, DRC_DRAIN, DRC_SLEEP} drc_state_t;
endpackage

/* hdl/drc_strobe_mux.sv */
`timescale 1ns/1ps
// ============================================================
// Frame strobe selector
module drc_strobe_mux (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Selection
  input wire logic [4:0] sel,
  input wire drc_pkg::drc_strobes_t src,
  // Selected strobe, registered
  output logic strobe
);
  import drc_pkg::*;
  logic [DRC_NUM_SRC-1:0] flat; // Flat source vector, index = code
  assign flat = src;
  // Codes above 16 select nothing, so no frames arrive
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strobe <= 1'b0;
    end else if (sel < DRC_NUM_SRC) begin
      strobe <= flat[sel];
    end else begin
      strobe <= 1'b0;
    end
  end
endmodule // drc_strobe_mux

/* hdl/drc_run_control.sv */
`timescale 1ns/1ps
// ============================================================
// Core run control registers
module drc_run_control (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Host control port
  input wire drc_pkg::drc_req_t req,
  output logic [15:0] rdata,
  output logic rvalid,
  // Frame strobe sources from clock generators and ports
  input wire drc_pkg::drc_strobes_t strobes,
  // Core handshake
  input wire logic frame_done,
  input wire logic [15:0] start_addr,
  output logic frame_strobe,
  output logic core_irq_en,
  output logic core_low_power,
  output logic pc_load,
  output logic [15:0] pc_start,
  output logic core_enable
);
  import drc_pkg::*;
  // ==========================================================
  // Registers
  logic lp_req_reg;          // Low-power request bit
  logic [4:0] sel_reg;       // Strobe selector
  logic launch_reg;          // Last written launch bit
  drc_state_t state_reg;     // Run sequencer
  logic launch_rise;         // Rising edge on a launch write
  logic strobe_w;            // Selected strobe
  logic drained;             // Current frame finished
  logic lp_wr;               // Write to low-power register
  // Edge found against the stored value, writes only
  assign launch_rise = req.wr && req.addr == DRC_ADDR_LAUNCH
                       && req.wdata[0] && !launch_reg;
  assign lp_wr = req.wr && req.addr == DRC_ADDR_LOW_POWER;
  assign drained = frame_done || strobe_w;
  // ==========================================================
  // Register writes, reserved bits dropped
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lp_req_reg <= DRC_RST_LOW_POWER[0];
      sel_reg <= DRC_RST_STROBE_SRC;
      launch_reg <= DRC_RST_LAUNCH[0];
    end else if (req.wr) begin
      if (lp_wr) begin
        lp_req_reg <= req.wdata[0];
      end
      if (req.addr == DRC_ADDR_STROBE_SRC) begin
        sel_reg <= req.wdata[4:0];
      end
      // Falling writes only update storage
      if (req.addr == DRC_ADDR_LAUNCH) begin
        launch_reg <= req.wdata[0];
      end
    end
  end
  // ==========================================================
  // Readback, one cycle later; unmapped reads zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 16'h0000;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      unique case (req.addr)
        DRC_ADDR_LOW_POWER: rdata <= {15'h0000, lp_req_reg};
        DRC_ADDR_STROBE_SRC: rdata <= {11'h000, sel_reg};
        DRC_ADDR_LAUNCH: rdata <= {15'h0000, launch_reg};
        default: rdata <= 16'h0000;
      endcase
    end
  end
  // ==========================================================
  // Run sequencer: a request waits for the frame end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= DRC_IDLE;
    end else begin
      unique case (state_reg)
        DRC_IDLE: if (launch_rise) state_reg <= DRC_RUN;
        DRC_RUN: if (lp_req_reg) state_reg <= DRC_DRAIN;
        DRC_DRAIN: if (drained) state_reg <= DRC_SLEEP;
        // Clearing the request resumes; a new launch does not leave sleep
        DRC_SLEEP: if (!lp_req_reg) state_reg <= DRC_RUN;
      endcase
    end
  end
  // ==========================================================
  // Core outputs
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      core_irq_en <= 1'b0;
      core_low_power <= 1'b0;
      core_enable <= 1'b0;
      pc_load <= 1'b0;
      pc_start <= DRC_RST_START_ADDR;
    end else begin
      // Masked in sleep; host stop relies on this path
      // Running core keeps interrupts until the frame ends, even with the request set
      core_irq_en <= !lp_req_reg || state_reg == DRC_RUN
                     || state_reg == DRC_DRAIN && !drained;
      // Cleared request drops low power at once, matching the interrupt path
      core_low_power <= lp_req_reg
                        && (state_reg == DRC_SLEEP || state_reg == DRC_DRAIN && drained);
      core_enable <= state_reg != DRC_IDLE || launch_rise;
      pc_load <= launch_rise;
      if (launch_rise) begin
        pc_start <= start_addr;
      end
    end
  end
  drc_strobe_mux u_mux (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .sel(sel_reg),
    .src(strobes),
    .strobe(strobe_w)
  );
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) frame_strobe <= 1'b0;
    else frame_strobe <= strobe_w;
  end
  // ==========================================================
  // Checks
  sequence s_launch;
    launch_rise;
  endsequence
  a_launch_loads_pc: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_launch |=> pc_load && core_enable && pc_start == $past(start_addr))
    else $error("launch did not load pc");
  a_fall_no_stop: assert property (@(posedge core_clk) disable iff (!arst_n)
    core_enable |=> core_enable)
    else $error("core enable dropped");
  a_sleep_masks_irq: assert property (@(posedge core_clk) disable iff (!arst_n)
    state_reg == DRC_SLEEP && lp_req_reg |=> !core_irq_en)
    else $error("irq enabled in low power");
  a_drain_waits_frame: assert property (@(posedge core_clk) disable iff (!arst_n)
    state_reg == DRC_DRAIN && !drained |=> state_reg == DRC_DRAIN)
    else $error("left drain early");
  a_sel_write: assert property (@(posedge core_clk) disable iff (!arst_n)
    req.wr && req.addr == DRC_ADDR_STROBE_SRC |=> sel_reg == $past(req.wdata[4:0]))
    else $error("selector not written");
  a_lp_read: assert property (@(posedge core_clk) disable iff (!arst_n)
    req.rd && req.addr == DRC_ADDR_LOW_POWER |=> rdata == {15'h0000, $past(lp_req_reg)})
    else $error("low power readback wrong");
  a_spdif_pick: assert property (@(posedge core_clk) disable iff (!arst_n)
    sel_reg == DRC_SEL_SPDIF && $stable(sel_reg) && strobes.spdif |=> ##1 frame_strobe)
    else $error("spdif strobe lost");
  a_gen1_base: assert property (@(posedge core_clk) disable iff (!arst_n)
    sel_reg == 5'h02 && strobes.gen1[2] |=> strobe_w)
    else $error("base rate strobe lost");
endmodule // drc_run_control

/* test/test_drc_run_control.sv */
`timescale 1ns/1ps
// ==========
// Self-checking bench for the run control registers
module test_drc_run_control;
  import drc_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  drc_req_t req = '0;
  drc_strobes_t strobes = '0;
  logic frame_done = 1'b0;
  logic [15:0] start_addr = 16'h0000;
  logic [15:0] rdata;
  logic [15:0] pc_start;
  logic rvalid, frame_strobe, core_irq_en, core_low_power, pc_load, core_enable;
  int bad_count = 0;
  int total_checks = 0;
  int hits;
  logic [15:0] v;
  logic [16:0] own; // Model: the one source bit a code should pass
  // Clock at 40 MHz
  always #12.5 core_clk = ~core_clk;
  drc_run_control i_drc_run_control (.core_clk(core_clk), .arst_n(arst_n), .req(req),
    .rdata(rdata), .rvalid(rvalid), .strobes(strobes), .frame_done(frame_done),
    .start_addr(start_addr), .frame_strobe(frame_strobe), .core_irq_en(core_irq_en),
    .core_low_power(core_low_power), .pc_load(pc_load), .pc_start(pc_start),
    .core_enable(core_enable));
  // ==========
  // Shared tasks
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Inputs always move 1 ns after the edge
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(logic [15:0] a, logic [15:0] d);
    // Request stays up until the next call replaces it; repeats are harmless
    req = '{1'b1, 1'b0, a, d};
    tick(1);
  endtask
  // Answer is registered, so it is visible right after the taking edge
  task automatic rd(logic [15:0] a, logic [15:0] exp);
    req = '{1'b0, 1'b1, a, 16'h0000};
    tick(1);
    chk("rvalid", 16'(rvalid), 16'h0001);
    chk("rdata", rdata, exp);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Watchdog, about sixteen times the expected run
  initial begin
    #(25 * 4000);
    bad_count++;
    results();
  end
  // ==========
  // Main sequence
  initial begin
    void'($urandom(32'hcc04));
    repeat (12) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    rd(DRC_ADDR_LOW_POWER, 16'h0000);
    rd(DRC_ADDR_STROBE_SRC, 16'h0002);
    rd(DRC_ADDR_LAUNCH, 16'h0000);
    chk("core_enable", 16'(core_enable), 16'h0000);
    $display("reset test done");
    // Reserved bits drop; unmapped places read zero and change nothing
    repeat (4) begin
      v = 16'($urandom);
      wr(DRC_ADDR_STROBE_SRC, v);
      rd(DRC_ADDR_STROBE_SRC, v & 16'h001f);
    end
    wr(DRC_ADDR_LOW_POWER, 16'hfffe);
    rd(DRC_ADDR_LOW_POWER, 16'h0000);
    wr(16'hf403, 16'hffff);
    rd(16'hf403, 16'h0000);
    rd(DRC_ADDR_STROBE_SRC, v & 16'h001f);
    $display("register test done");
    // Codes 0-17: other sources must not pass, its own must pass once (code 17 has none)
    // Strobes share the core clock, so no converter is needed here
    for (int c = 0; c < 18; c++) begin
      own = 17'h00001 << c;
      wr(DRC_ADDR_STROBE_SRC, 16'(c));
      for (int k = 0; k < 2; k++) begin
        strobes = drc_strobes_t'(k == 1 ? own : own ^ 17'h1ffff);
        hits = 0;
        repeat (5) begin
          tick(1);
          strobes = '0;
          if (frame_strobe === 1'b1) hits++;
        end
        chk("frame_strobe", 16'(hits), 16'(k == 1 && c < 17));
      end
    end
    wr(DRC_ADDR_STROBE_SRC, 16'h0002);
    $display("strobe test done");
    // Launch on rising edge only
    start_addr = 16'($urandom);
    wr(DRC_ADDR_LAUNCH, 16'h0001);
    chk("pc_load", 16'(pc_load), 16'h0001);
    chk("pc_start", pc_start, start_addr);
    tick(1);
    chk("pc_load", 16'(pc_load), 16'h0000);
    wr(DRC_ADDR_LAUNCH, 16'h0000);
    chk("core_enable", 16'(core_enable), 16'h0001);
    chk("pc_load", 16'(pc_load), 16'h0000);
    wr(DRC_ADDR_LAUNCH, 16'h0001);
    chk("pc_load", 16'(pc_load), 16'h0001);
    wr(DRC_ADDR_LAUNCH, 16'h0001);
    chk("pc_load", 16'(pc_load), 16'h0000);
    rd(DRC_ADDR_LAUNCH, 16'h0001);
    $display("launch test done");
    // Low power waits for the frame end, then masks interrupts
    // Stopping goes through the low-power bit, never the launch bit
    wr(DRC_ADDR_LOW_POWER, 16'h0001);
    // Host touches no other register until a frame has passed
    chk("core_irq_en", 16'(core_irq_en), 16'h0001);
    tick(3);
    chk("core_irq_en", 16'(core_irq_en), 16'h0001);
    chk("core_low_power", 16'(core_low_power), 16'h0000);
    frame_done = 1'b1;
    tick(1);
    frame_done = 1'b0;
    tick(3);
    chk("core_irq_en", 16'(core_irq_en), 16'h0000);
    chk("core_low_power", 16'(core_low_power), 16'h0001);
    rd(DRC_ADDR_LOW_POWER, 16'h0001);
    wr(DRC_ADDR_LOW_POWER, 16'h0000);
    tick(2);
    chk("core_irq_en", 16'(core_irq_en), 16'h0001);
    chk("core_low_power", 16'(core_low_power), 16'h0000);
    $display("low power test done");
    results();
  end
endmodule // test_drc_run_control
